//--- logic/afs_fault_status.sv
`timescale 1ns/10ps
// What this block does
// - short status upper nibble: active-low battery shorts
// - short status lower nibble: active-low ground shorts
// - offset status bit4 variant flag, 7:5 zero
// - offset bits live, active-low, valid in play
// - current faults latch channel hi-z; others not
// - faults reported; listed ones raise fault pin
// - load faults on clip pin A only when mapped
// - short results live while test enable set
// - flags name channel, not which output leg
// - standby select picks ground or battery test
// - battery above 6V, ground below 150mV
// - short results never block power-up
// - overcurrent flag latches, cleared writing one
module afs_fault_status
  import afs_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter bit VARIANT  = 1'b0  // arbitrary value standing in for the variant code
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire afs_sense_t  i_sense,
  input  wire afs_global_t i_global,
  input  wire afs_ctrl_t   i_ctrl,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_settled,
  output afs_out_t [3:0]   o_out_state,
  output logic             o_fault_pin_o,
  output logic             o_fault_pin_oe,
  output logic             o_clip_pin_a_o,
  output logic             o_clip_pin_a_oe,
  output logic             o_mute_clip_pin_b_o,
  output logic             o_mute_clip_pin_b_oe
);

  if (CHANNELS != 4) begin : g_chk
    $error("afs_fault_status serves exactly four channels");
  end

  logic [3:0]  battery_short_flag_q;
  logic [3:0]  ground_short_flag_q;
  logic [3:0]  offset_flag_q;
  logic [3:0]  overcurrent_flag_q;
  logic [3:0]  latched_off_q;
  logic [12:0] settle_cnt_q;
  logic        any_global_hiz;
  logic        fault_any;
  logic        load_fault;
  logic [3:0]  oc_clr;

  // one-hot style decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction : hit

  // write-one-to-clear mask of the overcurrent register, one bit per channel
  function automatic logic [3:0] oc_clear_mask(input logic       wr,
                                               input logic [7:0] a,
                                               input logic [7:0] wd);
    oc_clear_mask = (wr && hit(a, AFS_OVERCURRENT_IDX)) ? wd[7:4] : 4'h0;
  endfunction : oc_clear_mask

  // flag and latch share one clear decode, so only a shorted-load trip can make them disagree
  assign oc_clr = oc_clear_mask(i_wr, i_addr, i_wdata);

  // short diagnostic comparators; live, never latched, per channel only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      battery_short_flag_q <= AFS_FLAGS_CLEAR;
      ground_short_flag_q  <= AFS_FLAGS_CLEAR;
    end else if (i_ce) begin
      if (i_ctrl.short_test_enable) begin
        if (i_ctrl.standby_select) begin
          battery_short_flag_q <= ~i_sense.above_6v;
          ground_short_flag_q  <= AFS_FLAGS_CLEAR;
        end else begin
          battery_short_flag_q <= AFS_FLAGS_CLEAR;
          ground_short_flag_q  <= ~i_sense.below_150mv;
        end
      end else begin
        // outside the test the comparators mean nothing, so show no short
        battery_short_flag_q <= AFS_FLAGS_CLEAR;
        ground_short_flag_q  <= AFS_FLAGS_CLEAR;
      end
    end
  end

  // settle counter: tells the host when 200 us have passed in the test
  // it parks at the limit instead of wrapping, so the ready flag cannot drop mid-test
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      settle_cnt_q <= '0;
      o_settled    <= 1'b0;
    end else if (i_ce) begin
      if (!i_ctrl.short_test_enable) begin
        settle_cnt_q <= '0;
        o_settled    <= 1'b0;
      end else if (settle_cnt_q != 13'(AFS_SETTLE_CYC)) begin
        settle_cnt_q <= settle_cnt_q + 13'h0_001;
      end else begin
        o_settled <= 1'b1;
      end
    end
  end

  // offset flags follow the comparator; held clear outside quiet play
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      offset_flag_q <= AFS_FLAGS_CLEAR;
    end else if (i_ce) begin
      if (i_ctrl.play_mode && i_ctrl.precharge_done) begin
        offset_flag_q <= ~i_sense.offset_over;
      end else begin
        offset_flag_q <= AFS_FLAGS_CLEAR;
      end
    end
  end

  // overcurrent flags: trip wins over a same-cycle write-one clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      overcurrent_flag_q <= AFS_FLAGS_CLEAR;
    end else if (i_ce) begin
      for (int c = 0; c < 4; c++) begin
        if (i_sense.overcurrent[c]) begin
          overcurrent_flag_q[c] <= 1'b0;
        end else if (oc_clr[c]) begin
          overcurrent_flag_q[c] <= 1'b1;
        end
      end
    end
  end

  // channel latch-off; the short flags never feed it, so power-up proceeds
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      latched_off_q <= '0;
    end else if (i_ce) begin
      for (int c = 0; c < 4; c++) begin
        if (i_sense.overcurrent[c] || i_sense.shorted_load[c]) begin
          latched_off_q[c] <= 1'b1;
        end else if (oc_clr[c]) begin
          latched_off_q[c] <= 1'b0;
        end
      end
    end
  end

  // charge-pump undervoltage silences the outputs but stays off the fault pin
  assign any_global_hiz = i_global.uv | i_global.cp_uv | i_global.ot_shutdown;
  assign fault_any      = i_global.ov | i_global.uv | i_global.ot_shutdown
                        | i_global.ot_warn | ~(&overcurrent_flag_q)
                        | ~(&battery_short_flag_q) | ~(&ground_short_flag_q);
  assign load_fault     = |i_sense.load_trip;

  // output stage; overvoltage takes priority and parks outputs at mid rail
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int c = 0; c < 4; c++) begin
        o_out_state[c] <= AFS_OUT_HIZ;
      end
    end else if (i_ce) begin
      for (int c = 0; c < 4; c++) begin
        if (i_global.ov) begin
          o_out_state[c] <= AFS_OUT_HALF;
        end else if (any_global_hiz || latched_off_q[c]) begin
          o_out_state[c] <= AFS_OUT_HIZ;
        end else begin
          o_out_state[c] <= AFS_OUT_DRIVE;
        end
      end
    end
  end

  // open-drain pins: value is always low, enable pulls the line
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fault_pin_o        <= 1'b0;
      o_fault_pin_oe       <= 1'b0;
      o_clip_pin_a_o       <= 1'b0;
      o_clip_pin_a_oe      <= 1'b0;
      o_mute_clip_pin_b_o  <= 1'b0;
      o_mute_clip_pin_b_oe <= 1'b0;
    end else if (i_ce) begin
      o_fault_pin_oe       <= fault_any;
      o_clip_pin_a_oe      <= (i_ctrl.map_clip_to_pins && (|i_sense.clip))
                            || (i_ctrl.map_load_to_clip_a && load_fault);
      o_mute_clip_pin_b_oe <= i_ctrl.map_clip_to_pins && (|i_sense.clip);
    end
  end

  // read port: pure mux, so reading never disturbs any flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= AFS_READ_UNMAPPED;
    end else if (i_ce && i_rd) begin
      if (hit(i_addr, AFS_SHORT_STATUS_IDX)) begin
        o_rdata <= {battery_short_flag_q, ground_short_flag_q};
      end else if (hit(i_addr, AFS_OFFSET_STATUS_IDX)) begin
        o_rdata <= {3'b000, VARIANT, offset_flag_q};
      end else if (hit(i_addr, AFS_OVERCURRENT_IDX)) begin
        o_rdata <= {overcurrent_flag_q, ~i_sense.clip};
      end else begin
        o_rdata <= AFS_READ_UNMAPPED;
      end
    end
  end

  // assertions
  a_bat_flag_live: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_ctrl.short_test_enable && i_ctrl.standby_select
    |=> battery_short_flag_q == ~$past(i_sense.above_6v))
    else $error("battery flag does not follow comparator");
  a_gnd_flag_live: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_ctrl.short_test_enable && !i_ctrl.standby_select
    |=> ground_short_flag_q == ~$past(i_sense.below_150mv))
    else $error("ground flag does not follow comparator");
  a_idle_no_short: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && !i_ctrl.short_test_enable |=> battery_short_flag_q == 4'h_f)
    else $error("short flag set outside test");
  a_oc_latch: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_sense.overcurrent[0] |=> !overcurrent_flag_q[0])
    else $error("overcurrent flag did not latch");
  a_chan_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_sense.overcurrent[1] ##1 i_ce && !i_global.ov
    |=> o_out_state[1] == AFS_OUT_HIZ)
    else $error("overcurrent channel not high impedance");
  a_ov_half: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_global.ov |=> o_out_state[2] == AFS_OUT_HALF)
    else $error("overvoltage did not park outputs");
  a_fault_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_global.uv |=> o_fault_pin_oe)
    else $error("fault pin not pulled");
  a_unmapped_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && !i_ctrl.map_clip_to_pins && !i_ctrl.map_load_to_clip_a |=> !o_clip_pin_a_oe)
    else $error("clip pin driven while unmapped");
  a_variant_read: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_rd && i_addr == AFS_OFFSET_STATUS_IDX |=> o_rdata[7:4] == {3'b000, VARIANT})
    else $error("variant field wrong");

  // short diagnostic: the ground half during the battery test and the idle state read clear
  a_gnd_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && !i_ctrl.short_test_enable |=> ground_short_flag_q == AFS_FLAGS_CLEAR)
    else $error("ground flag set outside test");
  a_bat_sel_gnd: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_ctrl.short_test_enable && i_ctrl.standby_select
    |=> ground_short_flag_q == AFS_FLAGS_CLEAR)
    else $error("ground flag set during battery test");
  a_short_no_latch: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && latched_off_q == 4'h0 && i_sense.overcurrent == 4'h0
    && i_sense.shorted_load == 4'h0 |=> latched_off_q == 4'h0)
    else $error("channel latched without a current trip");

  // offset flags
  a_offset_live: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_ctrl.play_mode && i_ctrl.precharge_done
    |=> offset_flag_q == ~$past(i_sense.offset_over))
    else $error("offset flag does not follow comparator");
  a_offset_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && !(i_ctrl.play_mode && i_ctrl.precharge_done) |=> offset_flag_q == AFS_FLAGS_CLEAR)
    else $error("offset flag set outside quiet play");

  // overcurrent register, latches, reads and charge-pump undervoltage float
  a_oc_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_wr && i_addr == AFS_OVERCURRENT_IDX && i_wdata[6] && !i_sense.overcurrent[2]
    |=> overcurrent_flag_q[2])
    else $error("overcurrent flag not cleared by write");
  a_read_no_side: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_rd && !i_wr && i_sense.overcurrent == 4'h0 && i_sense.shorted_load == 4'h0
    |=> latched_off_q == $past(latched_off_q) && overcurrent_flag_q == $past(overcurrent_flag_q))
    else $error("read disturbed flag state");
  a_freeze_latch: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ce |=> $stable(latched_off_q) && $stable(overcurrent_flag_q))
    else $error("state moved while clock enable low");
  a_uv_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_global.cp_uv && !i_global.ov |=> o_out_state[3] == AFS_OUT_HIZ)
    else $error("supply fault did not float outputs");

  // open-drain pins
  a_oc_fault_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && !(&overcurrent_flag_q) |=> o_fault_pin_oe)
    else $error("overcurrent not on fault pin");
  a_clip_b_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_ctrl.map_clip_to_pins && (|i_sense.clip) |=> o_mute_clip_pin_b_oe)
    else $error("clip not on second clip pin");
  a_load_mapped: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && i_ctrl.map_load_to_clip_a && (|i_sense.load_trip) |=> o_clip_pin_a_oe)
    else $error("mapped load fault not on clip pin");

  c_bat_short: cover property (@(posedge i_clk) !battery_short_flag_q[3]);
  c_gnd_short: cover property (@(posedge i_clk) !ground_short_flag_q[0]);
  c_oc_clear:  cover property (@(posedge i_clk) !overcurrent_flag_q[2] ##1 overcurrent_flag_q[2]);
  c_settled:   cover property (@(posedge i_clk) o_settled);
  c_offset:    cover property (@(posedge i_clk) !offset_flag_q[3]);

endmodule : afs_fault_status

//--- logic/afs_pkg.sv
package afs_pkg;

  // status register indices inside the device register space
  localparam logic [7:0] AFS_SHORT_STATUS_IDX    = 8'h0_2;
  localparam logic [7:0] AFS_OFFSET_STATUS_IDX   = 8'h0_3;
  localparam logic [7:0] AFS_OVERCURRENT_IDX     = 8'h0_0;
  // field positions
  localparam int         AFS_BAT_LSB             = 4;
  localparam int         AFS_GND_LSB             = 0;
  localparam int         AFS_VARIANT_BIT         = 4;
  // reset values: active-low flags read 1 when nothing is wrong
  localparam logic [3:0] AFS_FLAGS_CLEAR         = 4'h_f;
  localparam logic [7:0] AFS_READ_UNMAPPED       = 8'h0_0;
  // short-test settle time
  localparam int         AFS_SETTLE_US           = 200;
  localparam int         AFS_CLK_MHZ             = 25;
  localparam int         AFS_SETTLE_CYC          = AFS_SETTLE_US * AFS_CLK_MHZ;

  // analog comparator results per channel, active high
  typedef struct packed {
    logic [3:0] above_6v;      // output above the battery threshold
    logic [3:0] below_150mv;   // output below the ground threshold
    logic [3:0] offset_over;   // differential offset beyond threshold
    logic [3:0] overcurrent;   // real-time overcurrent trip
    logic [3:0] shorted_load;  // shorted-load trip
    logic [3:0] clip;          // output clipping
    logic [3:0] load_trip;     // load/tweeter threshold exceeded
  } afs_sense_t;

  // chip-wide supply and temperature faults, active high
  typedef struct packed {
    logic ov;
    logic uv;
    logic cp_uv;
    logic ot_shutdown;
    logic ot_warn;
  } afs_global_t;

  // control bits set over the serial control port
  typedef struct packed {
    logic short_test_enable;
    logic output_discharge;
    logic standby_select;
    logic play_mode;
    logic precharge_done;
    logic map_load_to_clip_a;
    logic map_clip_to_pins;
  } afs_ctrl_t;

  typedef enum logic [1:0] {
    AFS_OUT_DRIVE,
    AFS_OUT_HALF,
    AFS_OUT_HIZ
  } afs_out_t;

endpackage : afs_pkg

//--- testbench/afs_host_model.sv
`timescale 1ns/10ps
module afs_host_model
  import afs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_settled,
  output logic            o_rd,
  output logic            o_wr,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata,
  output afs_ctrl_t       o_ctrl
);
  // idle host: no request, all control bits low
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h0_0;
    o_wdata = 8'h0_0;
    o_ctrl = '0;
  end
  // one-cycle read; data stands from the accepting edge until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    d = i_rdata;
    o_rd = 1'b0;
    o_addr = ~a;  // released index shows no stale value
    @(posedge i_clk);  // idle edge so a following request never overlaps this one
    #1;
  endtask : rd
  // one-cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    o_addr = a;
    o_wdata = v;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~v;
    @(posedge i_clk);
    #1;
  endtask : wr
  task automatic set_ctrl(input afs_ctrl_t c);
    o_ctrl = c;
    @(posedge i_clk);
    #1;
  endtask : set_ctrl
  // short diagnostic: discharge first, settle, read while enabled, clear
  task automatic short_test(input logic stby, output logic [7:0] d, output logic s);
    o_ctrl.play_mode = 1'b0;
    o_ctrl.standby_select = stby;
    o_ctrl.output_discharge = 1'b1;
    repeat (AFS_SETTLE_CYC) @(posedge i_clk);
    #1;
    o_ctrl.output_discharge = 1'b0;
    @(posedge i_clk);
    #1;
    o_ctrl.short_test_enable = 1'b1;
    repeat (AFS_SETTLE_CYC) @(posedge i_clk);
    #1;
    rd(AFS_SHORT_STATUS_IDX, d);
    s = i_settled;
    o_ctrl.short_test_enable = 1'b0;
    @(posedge i_clk);  // let the live flags fall back before anyone reads again
    #1;
  endtask : short_test
endmodule : afs_host_model

//--- testbench/afs_fault_status_tb_top.sv
`timescale 1ns/10ps
module afs_fault_status_tb_top
  import afs_pkg::*;
;
  logic           i_clk = 1'b0;
  logic           i_rst = 1'b1;
  afs_sense_t     sense = '0;
  afs_global_t    glob  = '0;
  afs_ctrl_t      ctrl;
  logic           rd, wr;
  logic [7:0]     addr, wdata, rdata, d;
  afs_out_t [3:0] st;
  logic           flt_oe, cla_oe, clb_oe;
  logic           ce = 1'b1;
  logic           settled, s;
  localparam bit  TB_VARIANT = 1'b0;  // arbitrary variant code
  int             fails = 0;
  int             checked = 0;
  localparam afs_out_t DR = AFS_OUT_DRIVE;
  localparam afs_out_t HZ = AFS_OUT_HIZ;
  // 25 MHz clock
  always #20 i_clk = ~i_clk;
  afs_host_model host (.i_clk(i_clk), .i_rdata(rdata), .i_settled(settled), .o_rd(rd),
    .o_wr(wr), .o_addr(addr), .o_wdata(wdata), .o_ctrl(ctrl));
  afs_fault_status #(.VARIANT(TB_VARIANT)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_sense(sense), .i_global(glob), .i_ctrl(ctrl), .i_rd(rd), .i_addr(addr), .i_wr(wr),
    .i_wdata(wdata), .o_rdata(rdata), .o_settled(settled), .o_out_state(st),
    .o_fault_pin_o(), .o_fault_pin_oe(flt_oe), .o_clip_pin_a_o(), .o_clip_pin_a_oe(cla_oe),
    .o_mute_clip_pin_b_o(), .o_mute_clip_pin_b_oe(clb_oe));
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: byte got %h expected %h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: bit got %b expected %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  // idle reads, an unmapped index, and a repeat read to show no side effect
  task automatic t_idle();
    host.rd(AFS_SHORT_STATUS_IDX, d);
    chk_byte(d, 8'h_ff);
    host.rd(AFS_OFFSET_STATUS_IDX, d);
    chk_byte(d, {3'b000, TB_VARIANT, AFS_FLAGS_CLEAR});
    host.rd(8'h0_1, d);
    chk_byte(d, AFS_READ_UNMAPPED);
    host.rd(AFS_SHORT_STATUS_IDX, d);
    chk_byte(d, 8'h_ff);
  endtask : t_idle
  // battery then ground test with shorts on both sides at once
  task automatic t_short();
    sense.above_6v = 4'b0101;
    sense.below_150mv = 4'b0010;
    host.short_test(1'b1, d, s);
    chk_byte(d, 8'ha_f);
    chk_bit(s, 1'b1);
    host.short_test(1'b0, d, s);
    chk_byte(d, 8'hf_d);
    host.rd(AFS_SHORT_STATUS_IDX, d);
    chk_byte(d, 8'h_ff);
    sense = '0;
  endtask : t_short
  // offset flags only count in play mode after precharge
  task automatic t_offset();
    sense.offset_over = 4'b1000;
    host.rd(AFS_OFFSET_STATUS_IDX, d);
    cyc(1);
    host.rd(AFS_OFFSET_STATUS_IDX, d);
    chk_byte(d, {3'b000, TB_VARIANT, AFS_FLAGS_CLEAR});
    host.set_ctrl(afs_ctrl_t'(7'b000_1100));
    cyc(1);
    host.rd(AFS_OFFSET_STATUS_IDX, d);
    chk_byte(d, {3'b000, TB_VARIANT, 4'b0111});
    host.set_ctrl('0);
    sense = '0;
  endtask : t_offset
  // a one-cycle trip latches channel 2 off until the host writes one
  task automatic t_overcurrent();
    sense.overcurrent = 4'b0100;
    cyc(1);
    sense = '0;
    cyc(3);
    chk_byte(st, {DR, HZ, DR, DR});
    chk_bit(flt_oe, 1'b1);
    host.rd(AFS_OVERCURRENT_IDX, d);
    chk_byte(d, 8'hb_f);
    host.wr(AFS_OVERCURRENT_IDX, 8'h4_0);
    cyc(3);
    host.rd(AFS_OVERCURRENT_IDX, d);
    chk_byte(d, 8'h_ff);
    chk_byte(st, {4{DR}});
  endtask : t_overcurrent
  // supply faults act on all channels without latching
  task automatic t_global();
    glob.ov = 1'b1;
    cyc(3);
    chk_byte(st, {4{AFS_OUT_HALF}});
    chk_bit(flt_oe, 1'b1);
    glob = '0;
    glob.cp_uv = 1'b1;
    cyc(3);
    chk_byte(st, {4{HZ}});
    chk_bit(flt_oe, 1'b0);
    glob = '0;
    cyc(3);
    chk_byte(st, {4{DR}});
  endtask : t_global
  // clip and load pins follow the mapping bits only
  task automatic t_clip();
    sense.clip = 4'b0001;
    sense.load_trip = 4'b0010;
    cyc(3);
    chk_bit(cla_oe, 1'b0);
    chk_bit(clb_oe, 1'b0);
    host.set_ctrl(afs_ctrl_t'(7'b000_0001));
    cyc(2);
    chk_bit(clb_oe, 1'b1);
    chk_bit(cla_oe, 1'b1);
    sense.clip = '0;
    host.set_ctrl(afs_ctrl_t'(7'b000_0010));
    cyc(2);
    chk_bit(cla_oe, 1'b1);
    chk_bit(clb_oe, 1'b0);
    host.set_ctrl('0);
    sense = '0;
  endtask : t_clip
  // a trip while the clock enable is low must leave no trace
  task automatic t_freeze();
    ce = 1'b0;
    sense.overcurrent = 4'b0001;
    cyc(2);
    sense = '0;
    ce = 1'b1;
    cyc(2);
    chk_bit(flt_oe, 1'b0);
    chk_byte(st, {4{DR}});
    host.rd(AFS_OVERCURRENT_IDX, d);
    chk_byte(d, 8'h_ff);
  endtask : t_freeze
  // a mid-run reset clears a latched overcurrent flag and its channel latch
  task automatic t_reset();
    sense.overcurrent = 4'b1000;
    cyc(1);
    sense = '0;
    i_rst = 1'b1;
    cyc(2);
    i_rst = 1'b0;
    host.rd(AFS_OVERCURRENT_IDX, d);
    chk_byte(d, 8'h_ff);
    chk_byte(st, {4{DR}});
  endtask : t_reset
  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge i_clk);
    fails++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_idle();
    t_short();
    t_offset();
    t_overcurrent();
    t_global();
    t_clip();
    t_freeze();
    t_reset();
    final_report();
  end
endmodule : afs_fault_status_tb_top
